// ===== logic/pmfc_cap_regs.sv
// capability slice: message data, release number, frame trim, express caps
`include "pmfc_params.svh"

module pmfc_cap_regs (
   input  wire logic                        CLK,
   input  wire logic                        RESETN,
   input  wire logic                        GLOBAL_RESETN,
   input  wire logic                        CE,
   input  wire pmfc_pkg::pmfc_cfg_req_type  CFG_REQ,
   output logic [31:0]                      CFG_RDATA,
   output logic                             CFG_ACK,
   input  wire logic [2:0]                  ENABLED_VECTOR_COUNT,
   input  wire logic                        MSG_SIGNAL_EN,
   input  wire logic                        IRQ_REQ,
   input  wire logic [4:0]                  IRQ_INTERRUPTER,
   input  wire logic [4:0]                  CAP_VECTOR_NUMBER,
   input  wire pmfc_pkg::pmfc_power_msg_type POWER_MSG,
   output pmfc_pkg::pmfc_msg_out_type       MSG_OUT,
   output logic [5:0]                       FRAME_PERIOD_TRIM,
   output logic [15:0]                      FRAME_PERIOD,
   output logic                             FRAME_TICK
);
   import pmfc_pkg::*;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // byte-enable merge of one lane group
   function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  be);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // mask of low payload bits that may carry the vector number
   function automatic logic [4:0] vec_mask(input logic [2:0] cnt);
      logic [4:0] m;
      case (cnt)
         3'h1:    m = 5'h01;
         3'h2:    m = 5'h03;
         3'h3:    m = 5'h07;
         3'h4:    m = 5'h0f;
         3'h5:    m = 5'h1f;
         default: m = 5'h00;
      endcase
      return m;
   endfunction

   logic [15:0] payload_r;
   logic [5:0]  trim_r;
   logic [1:0]  scale_r;
   logic [7:0]  value_r;
   logic [31:0] rdata_r;
   logic        ack_r;
   logic        irq_s1_r;
   logic        irq_s2_r;
   logic        irq_s3_r;
   logic [4:0]  int_s1_r;
   logic [4:0]  int_s2_r;
   pmfc_msg_out_type msg_r;

   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------
   // dword-aligned word select; byte lanes pick the register inside
   wire [7:0]  word_addr   = {CFG_REQ.addr[7:2], 2'b00};
   wire        hit_payload = (word_addr == `PMFC_OFF_PAYLOAD);
   wire        hit_rel     = (word_addr == `PMFC_OFF_RELEASE);
   wire        hit_cap     = (word_addr == `PMFC_OFF_CAP_ID);
   wire        hit_ep      = (word_addr == `PMFC_OFF_EP_CAPS);
   wire [31:0] wr_payload  = merge_be({16'h0000, payload_r}, CFG_REQ.wdata, CFG_REQ.be);
   wire [31:0] wr_rel      = merge_be({16'h0000, 2'b00, trim_r, `PMFC_VAL_RELEASE},
                                      CFG_REQ.wdata, CFG_REQ.be);
   wire        do_wr       = CFG_REQ.wr && !ack_r;
   wire        do_rd       = CFG_REQ.rd && !ack_r;

   // ------------------------------------------------------------
   // read words and read select
   // ------------------------------------------------------------
   // endpoint kind
   wire [15:0] exp_caps    = {2'b00, CAP_VECTOR_NUMBER, 1'b0,
                              `PMFC_VAL_PORT_KIND, `PMFC_VAL_CAP_VERSION};
   wire [31:0] ep_caps     = `PMFC_RST_EP_CAPS
                           | {4'h0, scale_r, value_r, 18'h00000};
   wire [31:0] cap_word    = {exp_caps, `PMFC_VAL_NEXT_CAP, `PMFC_VAL_CAP_ID};
   wire [31:0] rel_word    = {16'h0000, 2'b00, trim_r, `PMFC_VAL_RELEASE};
   wire [31:0] rd_mux      = hit_payload ? {16'h0000, payload_r} :
                             hit_rel     ? rel_word :
                             hit_cap     ? cap_word :
                             hit_ep      ? ep_caps  : 32'h0000_0000;

   // ------------------------------------------------------------
   // message payload register
   // ------------------------------------------------------------
   // payload storage
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         payload_r <= `PMFC_RST_PAYLOAD;
      end else if (CE && do_wr && hit_payload) begin
         payload_r <= wr_payload[15:0];
      end
   end

   // ------------------------------------------------------------
   // frame trim, sticky
   // ------------------------------------------------------------
   // only global or power-on reset
   always_ff @(posedge CLK or negedge GLOBAL_RESETN) begin
      if (!GLOBAL_RESETN) begin
         trim_r <= `PMFC_RST_TRIM;
      end else if (CE && do_wr && hit_rel) begin
         trim_r <= wr_rel[`PMFC_TRIM_MSB + 8:8];
      end
   end

   // ------------------------------------------------------------
   // power limit capture
   // ------------------------------------------------------------
   // payload 9:8 scale, 7:0 value
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         scale_r <= 2'b00;
         value_r <= 8'h00;
      end else if (CE && POWER_MSG.valid) begin
         scale_r <= POWER_MSG.payload[9:8];
         value_r <= POWER_MSG.payload[7:0];
      end
   end

   // ------------------------------------------------------------
   // read answer
   // ------------------------------------------------------------
   // one-cycle ack; unmapped words read zero, writes there dropped
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         rdata_r <= 32'h0000_0000;
         ack_r   <= 1'b0;
      end else if (CE) begin
         ack_r   <= (CFG_REQ.rd || CFG_REQ.wr) && !ack_r;
         if (do_rd) begin
            rdata_r <= rd_mux;
         end
      end
   end

   // ------------------------------------------------------------
   // interrupt request synchroniser
   // ------------------------------------------------------------
   // request may come from another clock, so two stages first
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         irq_s1_r <= 1'b0;
         irq_s2_r <= 1'b0;
         irq_s3_r <= 1'b0;
         int_s1_r <= 5'h00;
         int_s2_r <= 5'h00;
      end else if (CE) begin
         irq_s1_r <= IRQ_REQ;
         irq_s2_r <= irq_s1_r;
         irq_s3_r <= irq_s2_r;
         int_s1_r <= IRQ_INTERRUPTER;
         int_s2_r <= int_s1_r;
      end
   end

   // ------------------------------------------------------------
   // message composition
   // ------------------------------------------------------------
   // fold interrupter modulo enabled count
   wire [4:0]  vmask      = vec_mask(ENABLED_VECTOR_COUNT);
   wire [4:0]  vec_num    = int_s2_r & vmask;
   wire [4:0]  low_bits   = (payload_r[4:0] & ~vmask) | vec_num;
   wire [15:0] msg_final  = {payload_r[15:5], low_bits};
   wire        irq_rise   = irq_s2_r && !irq_s3_r;

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         msg_r <= '0;
      end else if (CE) begin
         msg_r.valid <= irq_rise && MSG_SIGNAL_EN;
         if (irq_rise && MSG_SIGNAL_EN) begin
            msg_r.data <= msg_final;
         end
      end
   end

   // ------------------------------------------------------------
   // frame timer
   // ------------------------------------------------------------
   // sticky trim drives the one frame timer
   pmfc_frame_timer u_timer (
      .clk        (CLK),
      .resetn     (RESETN),
      .ce         (CE),
      .trim       (trim_r),
      .frame_tick (FRAME_TICK),
      .period     (FRAME_PERIOD)
   );

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign CFG_RDATA         = rdata_r;
   assign CFG_ACK           = ack_r;
   assign MSG_OUT           = msg_r;
   assign FRAME_PERIOD_TRIM = trim_r;
endmodule

// ===== logic/pmfc_params.svh
// offsets, field positions, reset values and timing counts of the capability slice
`ifndef PMFC_PARAMS_SVH
`define PMFC_PARAMS_SVH

// ------------------------------------------------------------
// configuration byte offsets
// ------------------------------------------------------------
`define PMFC_OFF_PAYLOAD      8'h54
`define PMFC_OFF_RELEASE      8'h60
`define PMFC_OFF_TRIM         8'h61
`define PMFC_OFF_CAP_ID       8'h70
`define PMFC_OFF_NEXT_CAP     8'h71
`define PMFC_OFF_EXP_CAPS     8'h72
`define PMFC_OFF_EP_CAPS      8'h74

// ------------------------------------------------------------
// reset and constant values
// ------------------------------------------------------------
`define PMFC_RST_PAYLOAD      16'h0000
`define PMFC_VAL_RELEASE      8'h30
`define PMFC_RST_TRIM         6'h20
`define PMFC_VAL_CAP_ID       8'h10
`define PMFC_VAL_NEXT_CAP     8'hc0
`define PMFC_VAL_PORT_KIND    4'h0
`define PMFC_VAL_CAP_VERSION  4'h2
`define PMFC_RST_EP_CAPS      32'h0000_8fc3

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define PMFC_TRIM_MSB         5
`define PMFC_SYS_LSB          4
`define PMFC_SCALE_LSB        26
`define PMFC_VALUE_LSB        18
`define PMFC_VEC_NUM_LSB      9

// ------------------------------------------------------------
// frame timing: base in bit times, bit times per trim step
// ------------------------------------------------------------
`define PMFC_FRAME_BASE       16'd59488
`define PMFC_STEP_BITS        16'd16

`endif

// ===== logic/pmfc_pkg.sv
// types shared by the capability slice register bank
package pmfc_pkg;
   // configuration access from the link layer
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [7:0]  addr;
      logic [3:0]  be;
      logic [31:0] wdata;
   } pmfc_cfg_req_type;

   // received power limit message
   typedef struct packed {
      logic       valid;
      logic [9:0] payload;
   } pmfc_power_msg_type;

   // interrupt message write toward the transaction layer
   typedef struct packed {
      logic        valid;
      logic [15:0] data;
   } pmfc_msg_out_type;

   typedef enum logic [2:0] {
      PMFC_VEC_1, PMFC_VEC_2, PMFC_VEC_4, PMFC_VEC_8, PMFC_VEC_16, PMFC_VEC_32
   } pmfc_vec_count_type;
endpackage

// ===== logic/pmfc_frame_timer.sv
// start-of-frame counter with trim-adjusted period
`include "pmfc_params.svh"

module pmfc_frame_timer (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        ce,
   input  wire logic [5:0]  trim,
   output logic             frame_tick,
   output logic [15:0]      period
);
   import pmfc_pkg::*;

   logic [15:0] count_r;
   logic [15:0] count_nxt;
   logic        wrap;

   // ------------------------------------------------------------
   // period decode
   // ------------------------------------------------------------
   // period from trim
   // each trim step is sixteen bit times; top value still fits 16 bits
   assign period    = `PMFC_FRAME_BASE + `PMFC_STEP_BITS * {10'h000, trim};
   // new trim takes effect at once; a counter already past the new end wraps at the next edge
   assign wrap      = (count_r >= period - 16'd1);
   assign count_nxt = wrap ? 16'h0000 : count_r + 16'd1;

   // ------------------------------------------------------------
   // counter
   // ------------------------------------------------------------
   // free running frame counter
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         count_r    <= 16'h0000;
         frame_tick <= 1'b0;
      end else if (ce) begin
         count_r    <= count_nxt;
         frame_tick <= wrap;
      end
   end
endmodule

// ===== verif/pmfc_cap_regs_assertions.sv
// assertions on the capability slice register bank ports
module pmfc_cap_regs_checker (
   input wire logic                         CLK,
   input wire logic                         RESETN,
   input wire logic                         GLOBAL_RESETN,
   input wire logic                         CE,
   input wire pmfc_pkg::pmfc_cfg_req_type   CFG_REQ,
   input wire logic [31:0]                  CFG_RDATA,
   input wire logic                         CFG_ACK,
   input wire logic                         MSG_SIGNAL_EN,
   input wire logic                         IRQ_REQ,
   input wire logic [4:0]                   CAP_VECTOR_NUMBER,
   input wire pmfc_pkg::pmfc_power_msg_type POWER_MSG,
   input wire pmfc_pkg::pmfc_msg_out_type   MSG_OUT,
   input wire logic [5:0]                   FRAME_PERIOD_TRIM,
   input wire logic [15:0]                  FRAME_PERIOD
);
   logic        take;
   logic [5:0]  word;
   logic [15:0] pay_r;
   logic [15:0] pay_nxt;

   // dword decode, the two low address bits never select
   assign take    = CE && (CFG_REQ.rd || CFG_REQ.wr) && !CFG_ACK;
   assign word    = CFG_REQ.addr[7:2];
   assign pay_nxt = {CFG_REQ.be[1] ? CFG_REQ.wdata[15:8] : pay_r[15:8],
                     CFG_REQ.be[0] ? CFG_REQ.wdata[7:0] : pay_r[7:0]};

   // payload shadow, so message data can be judged without the body
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         pay_r <= 16'h0000;
      end else if (take && CFG_REQ.wr && word == 6'h15) begin
         pay_r <= pay_nxt;
      end
   end

   // ------------------------------------------
   // properties
   // ------------------------------------------
   default clocking dc @(posedge CLK);
   endclocking
   default disable iff (!RESETN || !GLOBAL_RESETN);

   a_period_sum: assert property (FRAME_PERIOD == 16'he860 + {6'h00, FRAME_PERIOD_TRIM, 4'h0})
      else $error("frame period is not base plus trim");
   a_trim_write: assert property (take && CFG_REQ.wr && word == 6'h18 && CFG_REQ.be[1]
      |=> FRAME_PERIOD_TRIM == $past(CFG_REQ.wdata[13:8])) else $error("trim not written");
   a_release_read: assert property (take && CFG_REQ.rd && word == 6'h18
      |=> CFG_RDATA[15:0] == {2'b00, FRAME_PERIOD_TRIM, 8'h30}) else $error("bad release word");
   a_caps_read: assert property (take && CFG_REQ.rd && word == 6'h1c
      |=> CFG_RDATA == {2'b00, $past(CAP_VECTOR_NUMBER), 9'h002, 16'hc010})
      else $error("bad capability word");
   a_ep_fixed_bits: assert property (take && CFG_REQ.rd && word == 6'h1d
      |=> CFG_RDATA[17:0] == 18'h0_8fc3 && CFG_RDATA[31:28] == 4'h0)
      else $error("bad endpoint caps fixed bits");
   a_payload_read: assert property (take && CFG_REQ.rd && word == 6'h15
      |=> CFG_RDATA[15:0] == pay_r) else $error("payload readback wrong");
   a_msg_latency: assert property ($rose(IRQ_REQ) && MSG_SIGNAL_EN
      |-> ##[2:4] MSG_OUT.valid) else $error("no message after request");
   a_sys_bits: assert property (MSG_OUT.valid |-> MSG_OUT.data[15:5] == pay_r[15:5])
      else $error("upper payload bits altered");

   c_message: cover property (MSG_OUT.valid);
   c_power: cover property (POWER_MSG.valid);
   c_trim_write: cover property (take && CFG_REQ.wr && word == 6'h18);
endmodule

bind pmfc_cap_regs pmfc_cap_regs_checker i_pmfc_cap_regs_checker (
   .CLK(CLK), .RESETN(RESETN), .GLOBAL_RESETN(GLOBAL_RESETN), .CE(CE),
   .CFG_REQ(CFG_REQ), .CFG_RDATA(CFG_RDATA), .CFG_ACK(CFG_ACK),
   .MSG_SIGNAL_EN(MSG_SIGNAL_EN), .IRQ_REQ(IRQ_REQ), .CAP_VECTOR_NUMBER(CAP_VECTOR_NUMBER),
   .POWER_MSG(POWER_MSG), .MSG_OUT(MSG_OUT), .FRAME_PERIOD_TRIM(FRAME_PERIOD_TRIM),
   .FRAME_PERIOD(FRAME_PERIOD));

// ===== verif/pmfc_host_model.sv
// host and link model: configuration accesses and power limit messages
module pmfc_host_model (
   input  wire logic                    CLK,
   input  wire logic                    CFG_ACK,
   input  wire logic [31:0]             CFG_RDATA,
   output pmfc_pkg::pmfc_cfg_req_type   CFG_REQ,
   output pmfc_pkg::pmfc_power_msg_type POWER_MSG
);
   timeunit 1ns;
   timeprecision 1ps;

   // idle at time zero
   initial begin
      CFG_REQ   = '0;
      POWER_MSG = '0;
   end

   // one access held until the acknowledge is sampled high
   task automatic xfer(input logic r, input logic [7:0] a, input logic [3:0] b,
                       input logic [31:0] d, output logic [31:0] q);
      int n = 0;
      @(negedge CLK);
      CFG_REQ = '{r, !r, a, b, d};
      // answer looked at mid-cycle, where it has settled
      do begin
         @(negedge CLK);
         n++;
      end while (CFG_ACK !== 1'b1 && n < 20);
      q = (CFG_ACK === 1'b1) ? CFG_RDATA : 'x;
      // request held through the rising edge that samples the acknowledge
      @(negedge CLK);
      // released lines show the inverse, never a stale copy
      CFG_REQ = '{1'b0, 1'b0, ~a, ~b, ~d};
   endtask

   // scale and value in one pulse
   task automatic power(input logic [9:0] p);
      @(negedge CLK);
      POWER_MSG = '{1'b1, p};
      @(negedge CLK);
      POWER_MSG = '{1'b0, ~p};
   endtask
endmodule

// ===== verif/pmfc_cap_regs_tb_top.sv
// self-checking bench for the capability slice register bank
module pmfc_cap_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   logic                         clk, resetn, global_resetn, ce, msg_en, irq_req, cfg_ack, tick;
   logic [2:0]                   vec_count;
   logic [4:0]                   irq_intr;
   logic [4:0]                   cap_vec;
   logic [5:0]                   trim;
   logic [15:0]                  period;
   logic [31:0]                  cfg_rdata;
   logic [31:0]                  rd;
   pmfc_pkg::pmfc_cfg_req_type   cfg_req;
   pmfc_pkg::pmfc_power_msg_type power_msg;
   pmfc_pkg::pmfc_msg_out_type   msg_out;
   int                           n_fail = 0;
   int                           n_checks = 0;
   int                           cycles = 0;

   pmfc_cap_regs i_pmfc_cap_regs (
      .CLK(clk), .RESETN(resetn), .GLOBAL_RESETN(global_resetn), .CE(ce),
      .CFG_REQ(cfg_req), .CFG_RDATA(cfg_rdata), .CFG_ACK(cfg_ack),
      .ENABLED_VECTOR_COUNT(vec_count), .MSG_SIGNAL_EN(msg_en), .IRQ_REQ(irq_req),
      .IRQ_INTERRUPTER(irq_intr), .CAP_VECTOR_NUMBER(cap_vec), .POWER_MSG(power_msg),
      .MSG_OUT(msg_out), .FRAME_PERIOD_TRIM(trim), .FRAME_PERIOD(period), .FRAME_TICK(tick));
   pmfc_host_model i_pmfc_host_model (
      .CLK(clk), .CFG_ACK(cfg_ack), .CFG_RDATA(cfg_rdata), .CFG_REQ(cfg_req),
      .POWER_MSG(power_msg));

   // ------------------------------------------
   // helpers
   // ------------------------------------------
   task automatic check(input string w, input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", w, e, s);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
      i_pmfc_host_model.xfer(1'b0, a, b, d, rd);
   endtask

   task automatic rdc(input string w, input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
      i_pmfc_host_model.xfer(1'b1, a, 4'hf, 32'h0000_0000, rd);
      check(w, rd & m, e);
   endtask

   // reset pulse held across one rising edge; a global one lowers both lines
   task automatic pulse(input bit g);
      @(negedge clk);
      resetn        = 1'b0;
      global_resetn = !g;
      @(negedge clk);
      resetn        = 1'b1;
      global_resetn = 1'b1;
   endtask

   // level request held seven cycles; counts messages seen in the first six
   task automatic irq_pulse(output int h, output logic [15:0] d);
      h = 0;
      repeat (3) @(negedge clk);
      irq_req = 1'b1;
      repeat (6) begin
         @(negedge clk);
         if (msg_out.valid === 1'b1) begin
            h++;
            d = msg_out.data;
         end
      end
      @(negedge clk);
      irq_req = 1'b0;
   endtask

   // ------------------------------------------
   // scenarios
   // ------------------------------------------
   task automatic t_defaults;
      rdc("payload", 8'h54, 32'h0000_ffff, 32'h0000_0000);
      rdc("release", 8'h60, 32'h0000_ffff, 32'h0000_2030);
      rdc("caps", 8'h70, 32'hffff_ffff, 32'h0002_c010);
      rdc("ep caps", 8'h74, 32'hffff_ffff, 32'h0000_8fc3);
      check("period", period, 32'h0000_ea60);
      $display("defaults done");
   endtask

   // all-ones writes land only on writable bits
   task automatic t_readonly;
      cap_vec = 5'h13;
      wr(8'h60, 4'hf, 32'hffff_ffff);
      wr(8'h70, 4'hf, 32'hffff_ffff);
      wr(8'h74, 4'hf, 32'hffff_ffff);
      wr(8'h58, 4'hf, 32'hffff_ffff);
      rdc("release", 8'h60, 32'h0000_ffff, 32'h0000_3f30);
      check("period", period, 32'h0000_ec50);
      rdc("caps", 8'h70, 32'hffff_ffff, {2'b00, 5'h13, 9'h002, 16'hc010});
      rdc("ep caps", 8'h74, 32'hffff_ffff, 32'h0000_8fc3);
      rdc("unmapped", 8'h58, 32'hffff_ffff, 32'h0000_0000);
      $display("readonly done");
   endtask

   task automatic t_msg;
      int          h;
      logic [15:0] d;
      logic [15:0] m;
      wr(8'h54, 4'h3, 32'h5a5a_abcd);
      wr(8'h54, 4'h1, 32'hffff_ff12);
      rdc("payload", 8'h54, 32'h0000_ffff, 32'h0000_ab12);
      msg_en   = 1'b1;
      irq_intr = 5'h0d;
      for (int c = 0; c < 7; c++) begin
         vec_count = c[2:0];
         m = (c < 6) ? 16'((1 << c) - 1) : 16'h0000;
         irq_pulse(h, d);
         check("msg count", h, 1);
         check("msg data", d, (16'hab12 & ~m) | (16'(irq_intr) & m));
      end
      msg_en = 1'b0;
      irq_pulse(h, d);
      check("msg disabled", h, 0);
      $display("message done");
   endtask

   task automatic t_power;
      i_pmfc_host_model.power(10'h2a5);
      rdc("power", 8'h74, 32'hffff_ffff, {4'h0, 2'b10, 8'ha5, 18'h0_8fc3});
      i_pmfc_host_model.power(10'h17e);
      rdc("power", 8'h74, 32'hffff_ffff, {4'h0, 2'b01, 8'h7e, 18'h0_8fc3});
      $display("power done");
   endtask

   task automatic t_sticky;
      wr(8'h60, 4'h2, 32'h0000_c500);
      pulse(1'b0);
      rdc("trim kept", 8'h60, 32'h0000_ffff, 32'h0000_0530);
      rdc("payload", 8'h54, 32'h0000_ffff, 32'h0000_0000);
      rdc("ep caps", 8'h74, 32'hffff_ffff, 32'h0000_8fc3);
      pulse(1'b1);
      rdc("trim reset", 8'h60, 32'h0000_ffff, 32'h0000_2030);
      check("period", period, 32'h0000_ea60);
      $display("sticky done");
   endtask

   // one whole frame after a core reset, with a 16-cycle enable freeze first
   task automatic t_frame;
      int n;
      pulse(1'b0);
      ce = 1'b0;
      for (n = 0; n < 16; n++) begin
         @(negedge clk);
      end
      ce = 1'b1;
      while (tick !== 1'b1 && n < 70000) begin
         @(negedge clk);
         n++;
      end
      check("frame length", n, 32'd60016);
      @(negedge clk);
      check("tick width", tick, 32'h0000_0000);
      $display("frame done");
   endtask

   task automatic test_done;
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // hang guard, above one full frame plus a few hundred access cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 70000) begin
         n_fail++;
         test_done;
      end
   end

   // main sequence, inputs changed on the falling edge
   initial begin
      {resetn, global_resetn, irq_req, msg_en} = 4'h0;
      ce        = 1'b1;
      vec_count = 3'h0;
      irq_intr  = 5'h00;
      cap_vec   = 5'h00;
      repeat (5) @(negedge clk);
      resetn        = 1'b1;
      global_resetn = 1'b1;
      t_defaults;
      t_readonly;
      t_msg;
      t_power;
      t_sticky;
      t_frame;
      test_done;
   end
endmodule
